// File: cspr_pkg.sv
// Constants for the processor state and pin register block.
// Assumes one clock, a synchronous active-high reset and sequencer-driven control ports.
// Summary of operation
// - Data registers take any value; no illegal-value detection on them.
// - Primary and alternate A, F, B, C, D, E, H, L, eight bits each.
// - SP, IX, IY kept as high/low bytes, plus vector page and refresh.
// - Four bank bits: AF select, general bank, DE/HL swap per bank.
// - Two interrupt enable flags and one interrupt mode bit held.
// - Low-byte carry latched for the high byte of 16-bit arithmetic.
// - Temporary bytes: opcode, PC, address, input data, write data, ALU.
// - Synchronisers and pin flops load every cycle with no enable.
// - Clear input passes three flops to form the internal clear.
// - Interrupt input uses two flops, non-maskable interrupt four.
// - Wait input sampled by one flop every cycle to stretch cycles.
// - Delayed second-state flop adds one wait in interrupt acknowledge.
// - Read, write, I/O, grant, data enable strobes use two flops each.
// - Status pins each driven by a dedicated flop.
// - One flop drives both address and control drive enables.
// - Only two sequencers need illegal-value detection and recovery.
// - SP, IX, IY, vector page, refresh reset on reset only; A..L on internal clear only.
// - Fault pin stays asserted while a guarded sequencer is illegal.
package cspr_pkg;
	localparam int DATA_W    = 8;
	localparam int GP_NUM    = 16;
	localparam int SYS_NUM   = 8;
	localparam int TMP_NUM   = 14;
	localparam int SEL_W     = 4;
	localparam int STRB_NUM  = 5;
	localparam int STAT_NUM  = 8;
	localparam int BREQ_SYNC = 2;
	localparam int CLR_SYNC  = 3;
	localparam int INT_SYNC  = 2;
	localparam int NMI_SYNC  = 4;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// Register file select codes
	localparam logic [3:0] RF_A   = 4'h0;
	localparam logic [3:0] RF_F   = 4'h1;
	localparam logic [3:0] RF_B   = 4'h2;
	localparam logic [3:0] RF_C   = 4'h3;
	localparam logic [3:0] RF_D   = 4'h4;
	localparam logic [3:0] RF_E   = 4'h5;
	localparam logic [3:0] RF_H   = 4'h6;
	localparam logic [3:0] RF_L   = 4'h7;
	localparam logic [3:0] RF_SPH = 4'h8;
	localparam logic [3:0] RF_R   = 4'hf;
	// Bit that moves D/E onto H/L when a bank's swap bit is set
	localparam logic [3:0] RF_SWAP_BIT = 4'h2;
	localparam logic [3:0] RF_ALT_BIT  = 4'h8;
	// Temporary register indices
	localparam int TMP_OPC  = 0;
	localparam int TMP_PCH  = 1;
	localparam int TMP_PCL  = 2;
	localparam int TMP_TOUT = 3;
	localparam int TMP_DOUT = 4;
	localparam int TMP_ADDH = 5;
	localparam int TMP_ADDL = 6;
	localparam int TMP_DATH = 7;
	localparam int TMP_DATL = 8;
	localparam int TMP_AINH = 9;
	localparam int TMP_AINL = 10;
	localparam int TMP_AOUT = 11;
	localparam int TMP_MOUT = 12;
	localparam int TMP_NORM = 13;
	// Strobe and status pin slots
	localparam int STB_RD = 0;
	localparam int STB_WR = 1;
	localparam int STB_IO = 2;
	localparam int STB_BA = 3;
	localparam int STB_DO = 4;
	localparam int ST_FLT = 0;
	localparam int ST_HLT = 1;
	localparam int ST_ACK = 2;
	localparam int ST_M1  = 3;
	localparam int ST_MRQ = 4;
	localparam int ST_SLP = 5;
	localparam int ST_STS = 6;
	localparam int ST_TRP = 7;
endpackage

// File: cspr_core_regs.sv
// Processor state registers, input synchronisers and registered pin drivers.
// Assumes the sequencers drive the request ports on the same clock.
`timescale 1ns/1ps
module cspr_core_regs import cspr_pkg::*; (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        clear_in_n,
	input  wire logic                        bus_request_in_n,
	input  wire logic                        maskable_irq_in_n,
	input  wire logic                        nonmaskable_irq_in_n,
	input  wire logic                        wait_in_n,
	input  wire logic                        rf_we,
	input  wire logic [SEL_W-1:0]            rf_wsel,
	input  wire logic [DATA_W-1:0]           rf_wdata,
	input  wire logic [SEL_W-1:0]            rf_rsel,
	input  wire logic                        swap_af,
	input  wire logic                        swap_bank,
	input  wire logic                        swap_dehl,
	input  wire logic                        ie_we,
	input  wire logic                        ie_one_wdata,
	input  wire logic                        ie_two_wdata,
	input  wire logic                        mode_we,
	input  wire logic                        mode_wdata,
	input  wire logic                        carry_we,
	input  wire logic                        carry_wdata,
	input  wire logic                        tmp_we,
	input  wire logic [SEL_W-1:0]            tmp_sel,
	input  wire logic [DATA_W-1:0]           tmp_wdata,
	input  wire logic                        in_second_state,
	input  wire logic                        irq_ack_cycle,
	input  wire logic [STRB_NUM-1:0]         strobe_req,
	input  wire logic [STAT_NUM-1:0]         status_req,
	input  wire logic                        seq_illegal,
	input  wire logic                        bus_released,
	output logic [DATA_W-1:0]                rf_rdata,
	output logic [TMP_NUM*DATA_W-1:0]        tmp_bus,
	output logic                             accum_flags_bank_select,
	output logic                             general_bank_select,
	output logic                             primary_dehl_swap,
	output logic                             alternate_dehl_swap,
	output logic                             interrupt_enable_flag_one,
	output logic                             interrupt_enable_flag_two,
	output logic                             interrupt_mode_bit,
	output logic                             low_byte_carry,
	output logic                             internal_clear_n,
	output logic                             bus_request_sync_n,
	output logic                             irq_sync_n,
	output logic                             nmi_sync_n,
	output logic                             wait_sampled_n,
	output logic                             second_state_delayed,
	output logic                             ack_wait_insert,
	output logic                             read_strobe_n,
	output logic                             write_strobe_n,
	output logic                             io_request_out_n,
	output logic                             bus_grant_out_n,
	output logic                             data_drive_enable_n,
	output logic                             illegal_state_out_n,
	output logic                             halted_out_n,
	output logic                             irq_acknowledge_out_n,
	output logic                             opcode_fetch_out_n,
	output logic                             memory_request_out_n,
	output logic                             sleeping_out_n,
	output logic                             status_out_n,
	output logic                             illegal_opcode_out_n,
	output logic                             address_drive_enable_n,
	output logic                             control_drive_enable_n
);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	// Synchronised pins idle high; all chains load every cycle
	logic [BREQ_SYNC-1:0] breq_sync_r;
	logic [CLR_SYNC-1:0]  clr_sync_r;
	logic [INT_SYNC-1:0]  int_sync_r;
	logic [NMI_SYNC-1:0]  nmi_sync_r;
	logic                 cpu_wait_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			breq_sync_r <= '1;
			clr_sync_r  <= '1;
			int_sync_r  <= '1;
			nmi_sync_r  <= '1;
			cpu_wait_r  <= 1'b1;
		end else begin
			breq_sync_r <= {breq_sync_r[BREQ_SYNC-2:0], bus_request_in_n};
			clr_sync_r  <= {clr_sync_r[CLR_SYNC-2:0], clear_in_n};
			int_sync_r  <= {int_sync_r[INT_SYNC-2:0], maskable_irq_in_n};
			nmi_sync_r  <= {nmi_sync_r[NMI_SYNC-2:0], nonmaskable_irq_in_n};
			// Single sampling flop; the wait pin must meet setup itself
			cpu_wait_r  <= wait_in_n;
		end
	end

	wire clr_act = ~clr_sync_r[CLR_SYNC-1];
	assign internal_clear_n   = clr_sync_r[CLR_SYNC-1];
	assign bus_request_sync_n = breq_sync_r[BREQ_SYNC-1];
	assign irq_sync_n         = int_sync_r[INT_SYNC-1];
	assign nmi_sync_n         = nmi_sync_r[NMI_SYNC-1];
	assign wait_sampled_n     = cpu_wait_r;

	// ************************************************************
	// Bank control and processor flags
	// ************************************************************
	logic       af_sel_r;
	logic       bank_sel_r;
	logic [1:0] dehl_r;
	logic       interrupt_enable_flag_one_r;
	logic       interrupt_enable_flag_two_r;
	logic       imode_r;
	logic       lcarry_r;

	wire [1:0] dehl_nxt = dehl_r ^ {bank_sel_r & swap_dehl, ~bank_sel_r & swap_dehl};

	always_ff @(posedge clk) begin
		if (rst || clr_act) begin
			af_sel_r   <= 1'b0;
			bank_sel_r <= 1'b0;
			dehl_r     <= 2'b00;
			interrupt_enable_flag_one_r     <= 1'b0;
			interrupt_enable_flag_two_r     <= 1'b0;
			imode_r    <= 1'b0;
			lcarry_r   <= 1'b0;
		end else begin
			af_sel_r   <= af_sel_r ^ swap_af;
			bank_sel_r <= bank_sel_r ^ swap_bank;
			dehl_r     <= dehl_nxt;
			if (ie_we) begin
				interrupt_enable_flag_one_r <= ie_one_wdata;
				interrupt_enable_flag_two_r <= ie_two_wdata;
			end
			if (mode_we) begin
				imode_r <= mode_wdata;
			end
			if (carry_we) begin
				lcarry_r <= carry_wdata;
			end
		end
	end

	assign accum_flags_bank_select   = af_sel_r;
	assign general_bank_select       = bank_sel_r;
	assign primary_dehl_swap         = dehl_r[0];
	assign alternate_dehl_swap       = dehl_r[1];
	assign interrupt_enable_flag_one = interrupt_enable_flag_one_r;
	assign interrupt_enable_flag_two = interrupt_enable_flag_two_r;
	assign interrupt_mode_bit        = imode_r;
	assign low_byte_carry            = lcarry_r;

	// ************************************************************
	// Register file
	// ************************************************************
	// Entries 0-7 primary A..L, 8-15 alternate; any byte is legal
	logic [DATA_W-1:0] gp_r  [GP_NUM];
	logic [DATA_W-1:0] sys_r [SYS_NUM];
	logic [DATA_W-1:0] rd_r;

	// Bank bits come in as arguments so a swap re-evaluates the mapping at once
	function automatic logic [SEL_W-1:0] map_sel(input logic [SEL_W-1:0] s, input logic af,
			input logic bank, input logic [1:0] dsw);
		logic       is_af;
		logic       alt;
		logic       is_dehl;
		logic [SEL_W-1:0] m;
		is_af   = (s == RF_A) || (s == RF_F);
		alt     = is_af ? af : bank;
		is_dehl = (s >= RF_D) && (s <= RF_L);
		m       = s;
		// Renaming just flips the D/H bit, so no data moves on a swap
		if (is_dehl && dsw[alt]) begin
			m = s ^ RF_SWAP_BIT;
		end
		if (alt) begin
			m = m | RF_ALT_BIT;
		end
		return m;
	endfunction

	wire              w_sys  = rf_wsel[3];
	wire [SEL_W-1:0]  w_phys = map_sel(rf_wsel, af_sel_r, bank_sel_r, dehl_r);
	wire [2:0]        w_sidx = rf_wsel[2:0];
	wire [SEL_W-1:0]  r_phys = map_sel(rf_rsel, af_sel_r, bank_sel_r, dehl_r);
	wire [2:0]        r_sidx = rf_rsel[2:0];
	wire [DATA_W-1:0] rd_nxt = rf_rsel[3] ? sys_r[r_sidx] : gp_r[r_phys];

	genvar gi;
	generate
		for (gi = 0; gi < GP_NUM; gi++) begin : g_gp
			always_ff @(posedge clk) begin
				if (clr_act) begin
					gp_r[gi] <= BYTE_RST;
				end else if (rf_we && !w_sys && w_phys == gi) begin
					gp_r[gi] <= rf_wdata;
				end
			end
		end
		for (gi = 0; gi < SYS_NUM; gi++) begin : g_sys
			always_ff @(posedge clk) begin
				if (rst) begin
					sys_r[gi] <= BYTE_RST;
				end else if (rf_we && w_sys && w_sidx == gi) begin
					sys_r[gi] <= rf_wdata;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_r <= BYTE_RST;
		end else begin
			rd_r <= rd_nxt;
		end
	end
	assign rf_rdata = rd_r;

	// ************************************************************
	// Temporary registers
	// ************************************************************
	logic [DATA_W-1:0] tmp_r [TMP_NUM];

	generate
		for (gi = 0; gi < TMP_NUM; gi++) begin : g_tmp
			always_ff @(posedge clk) begin
				if (rst) begin
					tmp_r[gi] <= BYTE_RST;
				end else if (tmp_we && tmp_sel == gi) begin
					tmp_r[gi] <= tmp_wdata;
				end
			end
			assign tmp_bus[gi*DATA_W +: DATA_W] = tmp_r[gi];
		end
	endgenerate

	// ************************************************************
	// Wait generation
	// ************************************************************
	logic t2d_r;
	logic ackw_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			t2d_r  <= 1'b0;
			ackw_r <= 1'b0;
		end else begin
			t2d_r  <= in_second_state;
			ackw_r <= in_second_state & irq_ack_cycle;
		end
	end
	assign second_state_delayed = t2d_r;
	assign ack_wait_insert      = ackw_r;

	// ************************************************************
	// Output pin flops
	// ************************************************************
	// Rising-edge stage follows the sequencer; falling-edge stage
	// shifts each strobe by half a clock to shape the pulse
	logic [STRB_NUM-1:0] strb_alt_r;
	logic [STRB_NUM-1:0] strb_reg_r;
	logic [STAT_NUM-1:0] stat_r;
	logic                drv_r;

	wire [STAT_NUM-1:0] fault_mask = STAT_NUM'(seq_illegal) << ST_FLT;

	always_ff @(posedge clk) begin
		if (rst) begin
			strb_alt_r <= '1;
			stat_r     <= '1;
			drv_r      <= 1'b0;
		end else begin
			strb_alt_r <= ~strobe_req;
			// Fault follows the guarded sequencers and status_req[ST_FLT]; others cannot go illegal
			stat_r     <= ~(status_req | fault_mask);
			drv_r      <= bus_released;
		end
	end

	always_ff @(negedge clk) begin
		if (rst) begin
			strb_reg_r <= '1;
		end else begin
			strb_reg_r <= strb_alt_r;
		end
	end

	assign read_strobe_n          = strb_reg_r[STB_RD];
	assign write_strobe_n         = strb_reg_r[STB_WR];
	assign io_request_out_n       = strb_reg_r[STB_IO];
	assign bus_grant_out_n        = strb_reg_r[STB_BA];
	assign data_drive_enable_n    = strb_reg_r[STB_DO];
	assign illegal_state_out_n    = stat_r[ST_FLT];
	assign halted_out_n           = stat_r[ST_HLT];
	assign irq_acknowledge_out_n  = stat_r[ST_ACK];
	assign opcode_fetch_out_n     = stat_r[ST_M1];
	assign memory_request_out_n   = stat_r[ST_MRQ];
	assign sleeping_out_n         = stat_r[ST_SLP];
	assign status_out_n           = stat_r[ST_STS];
	assign illegal_opcode_out_n   = stat_r[ST_TRP];
	assign address_drive_enable_n = drv_r;
	assign control_drive_enable_n = drv_r;

endmodule

// File: cspr_core_regs_asserts.sv
// Checker for the state and pin register block: synchroniser depths, pin flops, bank bits.
// Assumes it is bound to cspr_core_regs, one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module cspr_core_regs_chk import cspr_pkg::*; (
	input logic                clk,
	input logic                rst,
	input logic                clear_in_n,
	input logic                bus_request_in_n,
	input logic                maskable_irq_in_n,
	input logic                nonmaskable_irq_in_n,
	input logic                wait_in_n,
	input logic                swap_bank,
	input logic                in_second_state,
	input logic                irq_ack_cycle,
	input logic [STRB_NUM-1:0] strobe_req,
	input logic [STAT_NUM-1:0] status_req,
	input logic                seq_illegal,
	input logic                bus_released,
	input logic                general_bank_select,
	input logic                internal_clear_n,
	input logic                bus_request_sync_n,
	input logic                irq_sync_n,
	input logic                nmi_sync_n,
	input logic                wait_sampled_n,
	input logic                ack_wait_insert,
	input logic                read_strobe_n,
	input logic                write_strobe_n,
	input logic                illegal_state_out_n,
	input logic                halted_out_n,
	input logic                address_drive_enable_n,
	input logic                control_drive_enable_n
);
	// ****************
	// Settle guard
	// ****************
	// History from inside reset is not a valid pin history, so checks wait 7 edges
	logic [2:0] up_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			up_r <= 3'h0;
		end else if (up_r != 3'h7) begin
			up_r <= up_r + 3'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_rename;
		swap_bank && internal_clear_n;
	endsequence
	sequence s_bad;
		seq_illegal ##1 seq_illegal;
	endsequence
	property p_breq; up_r == 3'h7 |-> bus_request_sync_n == $past(bus_request_in_n, 2); endproperty
	a_breq: assert property (p_breq) else $error("bus request sync depth wrong");
	property p_clr; up_r == 3'h7 |-> internal_clear_n == $past(clear_in_n, 3); endproperty
	a_clr: assert property (p_clr) else $error("clear sync depth wrong");
	property p_irq; up_r == 3'h7 |-> irq_sync_n == $past(maskable_irq_in_n, 2); endproperty
	a_irq: assert property (p_irq) else $error("irq sync depth wrong");
	property p_nmi; up_r == 3'h7 |-> nmi_sync_n == $past(nonmaskable_irq_in_n, 4); endproperty
	a_nmi: assert property (p_nmi) else $error("nmi sync depth wrong");
	property p_wait; up_r == 3'h7 |-> wait_sampled_n == $past(wait_in_n); endproperty
	a_wait: assert property (p_wait) else $error("wait sample wrong");
	property p_ack; up_r == 3'h7 |-> ack_wait_insert == $past(in_second_state && irq_ack_cycle); endproperty
	a_ack: assert property (p_ack) else $error("auto wait term wrong");
	property p_strb;
		up_r == 3'h7 |-> read_strobe_n == !$past(strobe_req[STB_RD])
			&& write_strobe_n == !$past(strobe_req[STB_WR]);
	endproperty
	a_strb: assert property (p_strb) else $error("strobe pin timing wrong");
	property p_halt; up_r == 3'h7 |-> halted_out_n == !$past(status_req[ST_HLT]); endproperty
	a_halt: assert property (p_halt) else $error("halt pin wrong");
	property p_drv;
		up_r == 3'h7 |-> address_drive_enable_n == control_drive_enable_n
			&& address_drive_enable_n == $past(bus_released);
	endproperty
	a_drv: assert property (p_drv) else $error("drive enables differ");
	property p_clrbank; !internal_clear_n |=> !general_bank_select; endproperty
	a_clrbank: assert property (p_clrbank) else $error("bank bit not cleared");
	property p_swap; s_rename |=> general_bank_select != $past(general_bank_select); endproperty
	a_swap: assert property (p_swap) else $error("bank select did not flip");
	property p_fault; s_bad |-> !illegal_state_out_n ##1 !illegal_state_out_n; endproperty
	a_fault: assert property (p_fault) else $error("fault pin dropped");
endmodule
bind cspr_core_regs cspr_core_regs_chk u_chk (.*);

// File: cspr_ext_pins.sv
// Model of the outside parties that drive the asynchronous control pins.
// Assumes the bench sets levels at clock edges; order is clear, breq, irq, nmi, wait.
`timescale 1ns/1ps
module cspr_ext_pins (
	input  wire logic [4:0] lvl,
	output logic      [4:0] pins
);
	// ****************
	// Pin drivers
	// ****************
	// Skewed off the clock grid, as a free-running master would be
	assign #7 pins = lvl;
endmodule

// File: tb.sv
// Self-checking bench for the state and pin register block.
// Assumes a 50 MHz clock and the pin model for the asynchronous inputs.
`timescale 1ns/1ps
module tb;
	import cspr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] lvl = 5'h1f;
	logic [4:0] pins;
	logic rf_we, swap_af, swap_bank, swap_dehl, ie_we, ie_one_wdata, ie_two_wdata, mode_we;
	logic mode_wdata, carry_we, carry_wdata, tmp_we, in_second_state, irq_ack_cycle;
	logic seq_illegal, bus_released, accum_flags_bank_select, general_bank_select;
	logic [3:0] rf_wsel, rf_rsel, tmp_sel;
	logic [7:0] rf_wdata, tmp_wdata, rf_rdata, status_req;
	logic [4:0] strobe_req;
	logic [TMP_NUM*DATA_W-1:0] tmp_bus;
	logic primary_dehl_swap, alternate_dehl_swap, interrupt_enable_flag_one;
	logic interrupt_enable_flag_two, interrupt_mode_bit, low_byte_carry, internal_clear_n;
	logic bus_request_sync_n, irq_sync_n, nmi_sync_n, wait_sampled_n, second_state_delayed;
	logic ack_wait_insert, read_strobe_n, write_strobe_n, io_request_out_n, bus_grant_out_n;
	logic data_drive_enable_n, illegal_state_out_n, halted_out_n, irq_acknowledge_out_n;
	logic opcode_fetch_out_n, memory_request_out_n, sleeping_out_n, status_out_n;
	logic illegal_opcode_out_n, address_drive_enable_n, control_drive_enable_n;
	int err_total = 0;
	int samples_checked = 0;
	wire [4:0] sync_v = {wait_sampled_n, nmi_sync_n, irq_sync_n, bus_request_sync_n,
		internal_clear_n};
	wire [7:0] stat_v = {illegal_opcode_out_n, status_out_n, sleeping_out_n, memory_request_out_n,
		opcode_fetch_out_n, irq_acknowledge_out_n, halted_out_n, illegal_state_out_n};
	wire [4:0] strb_v = {data_drive_enable_n, bus_grant_out_n, io_request_out_n, write_strobe_n,
		read_strobe_n};
	wire [4:0] misc_v = {illegal_state_out_n, second_state_delayed, ack_wait_insert,
		address_drive_enable_n, control_drive_enable_n};
	cspr_ext_pins ext (.lvl(lvl), .pins(pins));
	cspr_core_regs uut (.*, .clear_in_n(pins[0]), .bus_request_in_n(pins[1]),
		.maskable_irq_in_n(pins[2]), .nonmaskable_irq_in_n(pins[3]), .wait_in_n(pins[4]));
	always #10 clk = ~clk;
	// ****************
	// Shared tasks
	// ****************
	task automatic end_of_test();
		if (err_total == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] s, input logic [7:0] d);
		@(posedge clk);
		rf_we <= 1'b1;
		rf_wsel <= s;
		rf_wdata <= d;
		@(posedge clk);
		rf_we <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] s, input logic [7:0] e);
		@(posedge clk);
		rf_rsel <= s;
		@(posedge clk);
		#1 chk(rf_rdata, e);
	endtask
	task automatic sw(input logic [2:0] v);
		@(posedge clk);
		{swap_dehl, swap_bank, swap_af} <= v;
		@(posedge clk);
		{swap_dehl, swap_bank, swap_af} <= 3'h0;
	endtask
	task automatic pulse_pin(input int i, input int n);
		@(posedge clk);
		lvl[i] <= 1'b0;
		repeat (n) @(posedge clk);
		lvl[i] <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_sync();
		int lat[5] = '{3, 2, 2, 4, 1};
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			lvl[i] <= 1'b0;
			repeat (lat[i] - 1) @(posedge clk);
			#1 chk({7'h00, sync_v[i]}, 8'h01);
			@(posedge clk);
			#1 chk({7'h00, sync_v[i]}, 8'h00);
			@(posedge clk);
			lvl[i] <= 1'b1;
			repeat (6) @(posedge clk);
		end
	endtask
	task automatic t_regs();
		wr(RF_A, 8'h55);
		sw(3'h1);
		wr(RF_A, 8'haa);
		rd(RF_A, 8'haa);
		sw(3'h1);
		rd(RF_A, 8'h55);
		wr(RF_D, 8'h12);
		wr(RF_H, 8'h34);
		sw(3'h4);
		rd(RF_H, 8'h12);
		rd(RF_D, 8'h34);
		sw(3'h4);
		sw(3'h2);
		sw(3'h4);
		#1 chk({5'h00, general_bank_select, alternate_dehl_swap, primary_dehl_swap}, 8'h06);
		sw(3'h4);
		wr(RF_B, 8'hff);
		rd(RF_B, 8'hff);
		sw(3'h2);
		rd(RF_B, 8'h00);
		wr(RF_SPH, 8'hc3);
		wr(RF_R, 8'ha5);
		rd(RF_R, 8'ha5);
	endtask
	task automatic t_misc();
		@(posedge clk);
		{ie_we, ie_one_wdata, ie_two_wdata, mode_we, mode_wdata, carry_we, carry_wdata} <= 7'h5f;
		for (int k = 0; k < TMP_NUM; k++) begin
			@(posedge clk);
			{ie_we, mode_we, carry_we} <= 3'h0;
			tmp_we <= 1'b1;
			tmp_sel <= 4'(k);
			tmp_wdata <= 8'(k * 17 + 3);
		end
		@(posedge clk);
		tmp_we <= 1'b0;
		#1 chk({4'h0, interrupt_enable_flag_one, interrupt_enable_flag_two, interrupt_mode_bit,
			low_byte_carry}, 8'h07);
		for (int k = 0; k < TMP_NUM; k++) chk(tmp_bus[8*k +: 8], 8'(k * 17 + 3));
	endtask
	task automatic t_pins();
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			status_req <= 8'h01 << i;
			@(posedge clk);
			#1 chk(stat_v, ~(8'h01 << i));
		end
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			status_req <= 8'h00;
			strobe_req <= 5'h01 << i;
			@(posedge clk);
			@(negedge clk);
			#1 chk({3'h0, strb_v}, {3'h0, ~(5'h01 << i)});
		end
		@(posedge clk);
		strobe_req <= 5'h00;
		{seq_illegal, in_second_state, irq_ack_cycle, bus_released} <= 4'hd;
		@(posedge clk);
		{seq_illegal, in_second_state, irq_ack_cycle, bus_released} <= 4'hf;
		#1 chk({3'h0, misc_v}, 8'h0b);
		repeat (3) begin
			@(posedge clk);
			#1 chk({3'h0, misc_v}, 8'h0f);
		end
		@(posedge clk);
		{seq_illegal, in_second_state, irq_ack_cycle, bus_released} <= 4'h0;
		@(posedge clk);
		#1 chk({3'h0, misc_v}, 8'h10);
	endtask
	task automatic t_clear();
		sw(3'h1);
		pulse_pin(0, 2);
		#1 chk({7'h00, accum_flags_bank_select}, 8'h00);
		rd(RF_A, 8'h00);
		rd(RF_SPH, 8'hc3);
		rd(RF_R, 8'ha5);
	endtask
	initial begin
		{rf_we, swap_af, swap_bank, swap_dehl, ie_we, ie_one_wdata, ie_two_wdata, mode_we,
			mode_wdata, carry_we, carry_wdata, tmp_we, in_second_state, irq_ack_cycle,
			seq_illegal, bus_released, rf_wsel, rf_rsel, tmp_sel, rf_wdata, tmp_wdata,
			status_req, strobe_req} = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(RF_SPH, 8'h00);
		t_sync();
		t_regs();
		t_misc();
		t_pins();
		t_clear();
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_of_test();
	end
endmodule
